// ### verilog/walk_cache_tuning_regs.sv
// Walk cache tuning register bank with AXI4-Lite slave and walk cache index lookup port.
// Assumes synchronous inputs on aclk; awprot[1]/arprot[1] high marks a non-secure access.
//
// How it works
// - Tuning access bit clear: non-secure control reads zero, writes dropped.
// - Control writes take effect only while both translation enables are zero.
// - Address-only setting indexes the walk cache from input address alone.
// - Hashed setting combines address space id, machine id and input address.
// - Hashed setting: invalidation without address space id scans whole cache.
// - Bit 15 set disables the stage 2 level 3 walk cache.
// - Bit 14 set disables the stage 2 level 2 walk cache.
// - Bit 13 set disables the stage 2 level 1 walk cache.
// - Bit 12 set disables the stage 2 level 0 walk cache.
// - Bit 11 set disables the stage 1 level 3 walk cache.
// - Bit 10 set disables the stage 1 level 2 walk cache.
// - Bits 9 and 8 set disable stage 1 level 1 and 0 caches.
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ns
`include "walk_cache_defs.svh"

module walk_cache_tuning_regs (
	input  wire logic                   aclk,            // Clock, 100 MHz
	input  wire logic                   aresetn,         // Synchronous reset, active low
	input  wire logic [`ADDR_W-1:0]     s_axi_awaddr,    // Write address
	input  wire logic [2:0]             s_axi_awprot,    // Write protection
	input  wire logic                   s_axi_awvalid,   // Write address valid
	output logic                        s_axi_awready,   // Write address ready
	input  wire logic [31:0]            s_axi_wdata,     // Write data
	input  wire logic [3:0]             s_axi_wstrb,     // Write byte strobes
	input  wire logic                   s_axi_wvalid,    // Write data valid
	output logic                        s_axi_wready,    // Write data ready
	output logic [1:0]                  s_axi_bresp,     // Write response
	output logic                        s_axi_bvalid,    // Write response valid
	input  wire logic                   s_axi_bready,    // Write response ready
	input  wire logic [`ADDR_W-1:0]     s_axi_araddr,    // Read address
	input  wire logic [2:0]             s_axi_arprot,    // Read protection
	input  wire logic                   s_axi_arvalid,   // Read address valid
	output logic                        s_axi_arready,   // Read address ready
	output logic [31:0]                 s_axi_rdata,     // Read data
	output logic [1:0]                  s_axi_rresp,     // Read response
	output logic                        s_axi_rvalid,    // Read data valid
	input  wire logic                   s_axi_rready,    // Read data ready
	input  wire logic                   lookup_valid,    // Walk cache lookup request
	input  wire logic [`IN_ADDR_W-1:0]  lookup_addr,     // Input address of request
	input  wire logic [`ID_W-1:0]       lookup_asid,     // Address space identifier
	input  wire logic [`ID_W-1:0]       lookup_vmid,     // Virtual machine identifier
	input  wire logic                   lookup_stage2,   // High for a stage 2 walk
	input  wire logic [1:0]             lookup_level,    // Walk level 0 to 3
	input  wire logic                   lookup_inval,    // Request is an invalidation
	input  wire logic                   lookup_has_asid, // Invalidation carries an ASID
	output logic                        result_valid,    // Lookup result valid, one cycle
	output walk_cache_pkg::idx_t        result_index,    // Computed walk cache index
	output logic                        result_use,      // Walk cache at this level in use
	output logic                        result_scan_all, // Invalidation must scan all
	output logic [7:0]                  walkcache_off,   // Per stage and level disables
	output logic                        identifier_hashed_indexing // Hashed index mode
);
	walk_cache_pkg::wr_state_t wr_state_q, wr_state_d;
	walk_cache_pkg::rd_state_t rd_state_q, rd_state_d;
	logic                  aw_have_q, aw_have_d;
	logic                  w_have_q, w_have_d;
	logic [`ADDR_W-1:0]    waddr_q, waddr_d;
	logic                  wns_q, wns_d;
	logic [31:0]           wdata_q, wdata_d;
	logic [3:0]            wstrb_q, wstrb_d;
	logic                  awready_q, awready_d;
	logic                  wready_q, wready_d;
	logic                  bvalid_q, bvalid_d;
	logic [1:0]            bresp_q, bresp_d;
	logic                  arready_q, arready_d;
	logic                  rvalid_q, rvalid_d;
	logic [31:0]           rdata_q, rdata_d;
	logic [1:0]            rresp_q, rresp_d;

	logic [31:0]           ctrl_q, ctrl_d;
	logic [31:0]           scr_q, scr_d;
	logic [1:0]            xlate_en_q, xlate_en_d;

	logic                  res_valid_q, res_valid_d;
	walk_cache_pkg::idx_t  res_index_q, res_index_d;
	logic                  res_use_q, res_use_d;
	logic                  res_scan_q, res_scan_d;
	logic [7:0]            off_q, off_d;
	logic                  hashed_q, hashed_d;

	logic                  wr_fire;
	logic                  ns_access;
	logic                  xlate_off;
	logic [31:0]           strb_mask;
	logic [`ADDR_W-1:0]    wa;
	logic [`ADDR_W-1:0]    ra;
	logic                  rns;

	walk_cache_if wc ();

	walk_cache_index u_index (
		.wc (wc)
	);

	// Mapped word test, shared by both paths
	function automatic logic mapped(input logic [`ADDR_W-1:0] a);
		mapped = (a == `CTRL_OFFSET) || (a == `PRIO_OFFSET) || (a == `SLOTCFG_OFFSET) ||
			(a == `SLOTSTAT_OFFSET) || (a == `SCR_OFFSET) || (a == `XLATE_EN_OFFSET) ||
			((a >= `NODE_CTRL_BASE) && (a <= `NODE_STAT_LAST));
	endfunction

	assign ns_access = scr_q[`SCR_NS_ACCESS_BIT];
	assign xlate_off = (xlate_en_q[`XLATE_NS_BIT] == 1'b0) && (xlate_en_q[`XLATE_S_BIT] == 1'b0);
	assign wa        = {waddr_q[`ADDR_W-1:2], 2'h0};
	assign ra        = {s_axi_araddr[`ADDR_W-1:2], 2'h0};
	assign rns       = s_axi_arprot[1];
	assign strb_mask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
	assign wr_fire   = (wr_state_q == walk_cache_pkg::WR_IDLE) && aw_have_q && w_have_q;

	// Write path: address and data taken in either order, one response after both
	always_comb begin
		wr_state_d = wr_state_q;
		aw_have_d  = aw_have_q;
		w_have_d   = w_have_q;
		waddr_d    = waddr_q;
		wns_d      = wns_q;
		wdata_d    = wdata_q;
		wstrb_d    = wstrb_q;
		bvalid_d   = bvalid_q;
		bresp_d    = bresp_q;
		if (s_axi_awvalid && awready_q) begin
			aw_have_d = 1'b1;
			waddr_d   = s_axi_awaddr;
			wns_d     = s_axi_awprot[1];
		end
		if (s_axi_wvalid && wready_q) begin
			w_have_d = 1'b1;
			wdata_d  = s_axi_wdata;
			wstrb_d  = s_axi_wstrb;
		end
		case (wr_state_q)
			walk_cache_pkg::WR_IDLE: begin
				if (wr_fire) begin
					aw_have_d  = 1'b0;
					w_have_d   = 1'b0;
					bvalid_d   = 1'b1;
					bresp_d    = mapped(wa) ? `RESP_OKAY : `RESP_SLVERR;
					wr_state_d = walk_cache_pkg::WR_RESP;
				end
			end
			walk_cache_pkg::WR_RESP: begin
				if (s_axi_bready) begin
					bvalid_d   = 1'b0;
					wr_state_d = walk_cache_pkg::WR_IDLE;
				end
			end
			default: begin
				bvalid_d   = 1'b0;
				wr_state_d = walk_cache_pkg::WR_IDLE;
			end
		endcase
		awready_d = (wr_state_d == walk_cache_pkg::WR_IDLE) && !aw_have_d;
		wready_d  = (wr_state_d == walk_cache_pkg::WR_IDLE) && !w_have_d;
	end

	// Register contents
	always_comb begin
		ctrl_d     = ctrl_q;
		scr_d      = scr_q;
		xlate_en_d = xlate_en_q;
		if (wr_fire) begin
			if ((wa == `CTRL_OFFSET) && (!wns_q || ns_access) && xlate_off) begin
				ctrl_d = (ctrl_q & ~strb_mask) | (wdata_q & strb_mask);
			end
			if ((wa == `SCR_OFFSET) && !wns_q) begin
				scr_d = (scr_q & ~strb_mask) | (wdata_q & strb_mask);
			end
			if ((wa == `XLATE_EN_OFFSET) && wstrb_q[0]) begin
				xlate_en_d[`XLATE_NS_BIT] = wdata_q[`XLATE_NS_BIT];
				if (!wns_q) begin
					xlate_en_d[`XLATE_S_BIT] = wdata_q[`XLATE_S_BIT];
				end
			end
		end
	end

	// Read path: one read at a time, answer one cycle after the address is taken
	always_comb begin
		rd_state_d = rd_state_q;
		rvalid_d   = rvalid_q;
		rdata_d    = rdata_q;
		rresp_d    = rresp_q;
		case (rd_state_q)
			walk_cache_pkg::RD_IDLE: begin
				if (s_axi_arvalid && arready_q) begin
					rvalid_d   = 1'b1;
					rdata_d    = 32'h0000_0000;
					rresp_d    = mapped(ra) ? `RESP_OKAY : `RESP_SLVERR;
					rd_state_d = walk_cache_pkg::RD_RESP;
					if ((ra == `CTRL_OFFSET) && (!rns || ns_access)) begin
						rdata_d = ctrl_q;
					end
					if ((ra == `SCR_OFFSET) && !rns) begin
						rdata_d = scr_q;
					end
					if (ra == `XLATE_EN_OFFSET) begin
						rdata_d = {30'h0000_0000, xlate_en_q};
					end
				end
			end
			walk_cache_pkg::RD_RESP: begin
				if (s_axi_rready) begin
					rvalid_d   = 1'b0;
					rd_state_d = walk_cache_pkg::RD_IDLE;
				end
			end
			default: begin
				rvalid_d   = 1'b0;
				rd_state_d = walk_cache_pkg::RD_IDLE;
			end
		endcase
		arready_d = (rd_state_d == walk_cache_pkg::RD_IDLE);
	end

	// Lookup port through the index calculator
	always_comb begin
		wc.walkcache_off = ctrl_q[`OFF_S2_BASE+3:`OFF_S1_BASE];
		wc.hashed        = ctrl_q[`HASH_BIT];
		wc.in_addr       = lookup_addr;
		wc.asid          = lookup_asid;
		wc.vmid          = lookup_vmid;
		wc.stage         = lookup_stage2 ? walk_cache_pkg::STAGE_TWO : walk_cache_pkg::STAGE_ONE;
		wc.level         = lookup_level;
		wc.inv_has_asid  = lookup_has_asid;
		res_valid_d      = lookup_valid;
		res_index_d      = wc.index;
		res_use_d        = wc.use_cache;
		res_scan_d       = lookup_inval & wc.scan_all;
		off_d            = wc.walkcache_off;
		hashed_d         = wc.hashed;
	end

	// Write channel state
	// Readys are flops: each drops on the same edge that takes its half,
	// so a held address or data word is never overwritten
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_state_q  <= walk_cache_pkg::WR_IDLE;
			aw_have_q   <= 1'b0;
			w_have_q    <= 1'b0;
			waddr_q     <= 16'h0000;
			wns_q       <= 1'b0;
			wdata_q     <= 32'h0000_0000;
			wstrb_q     <= 4'h0;
			awready_q   <= 1'b0;
			wready_q    <= 1'b0;
			bvalid_q    <= 1'b0;
			bresp_q     <= `RESP_OKAY;
		end else begin
			wr_state_q  <= wr_state_d;
			aw_have_q   <= aw_have_d;
			w_have_q    <= w_have_d;
			waddr_q     <= waddr_d;
			wns_q       <= wns_d;
			wdata_q     <= wdata_d;
			wstrb_q     <= wstrb_d;
			awready_q   <= awready_d;
			wready_q    <= wready_d;
			bvalid_q    <= bvalid_d;
			bresp_q     <= bresp_d;
		end
	end

	// Read channel state
	// Address ready stays low while an answer waits: one read in flight
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_state_q  <= walk_cache_pkg::RD_IDLE;
			arready_q   <= 1'b0;
			rvalid_q    <= 1'b0;
			rdata_q     <= 32'h0000_0000;
			rresp_q     <= `RESP_OKAY;
		end else begin
			rd_state_q  <= rd_state_d;
			arready_q   <= arready_d;
			rvalid_q    <= rvalid_d;
			rdata_q     <= rdata_d;
			rresp_q     <= rresp_d;
		end
	end

	// Register contents
	// Control and SCR spare bits are stored as written; software keeps them at zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q      <= `CTRL_RESET;
			scr_q       <= `SCR_RESET;
			xlate_en_q  <= `XLATE_EN_RESET;
		end else begin
			ctrl_q      <= ctrl_d;
			scr_q       <= scr_d;
			xlate_en_q  <= xlate_en_d;
		end
	end

	// Lookup results, one cycle behind the request
	// Mirrors of the control bits that the same result was built from
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			res_valid_q <= 1'b0;
			res_index_q <= 8'h00;
			res_use_q   <= 1'b0;
			res_scan_q  <= 1'b0;
			off_q       <= 8'h00;
			hashed_q    <= 1'b0;
		end else begin
			res_valid_q <= res_valid_d;
			res_index_q <= res_index_d;
			res_use_q   <= res_use_d;
			res_scan_q  <= res_scan_d;
			off_q       <= off_d;
			hashed_q    <= hashed_d;
		end
	end

	assign s_axi_awready              = awready_q;
	assign s_axi_wready               = wready_q;
	assign s_axi_bvalid               = bvalid_q;
	assign s_axi_bresp                = bresp_q;
	assign s_axi_arready              = arready_q;
	assign s_axi_rvalid               = rvalid_q;
	assign s_axi_rdata                = rdata_q;
	assign s_axi_rresp                = rresp_q;
	assign result_valid               = res_valid_q;
	assign result_index               = res_index_q;
	assign result_use                 = res_use_q;
	assign result_scan_all            = res_scan_q;
	assign walkcache_off              = off_q;
	assign identifier_hashed_indexing = hashed_q;
endmodule

// ### verilog/walk_cache_defs.svh
// Constants of the walk cache tuning register bank: map, fields, resets, sizes.
// Assumes byte addresses on a 32-bit AXI4-Lite bus, one register per aligned word.
`ifndef WALK_CACHE_DEFS_SVH
`define WALK_CACHE_DEFS_SVH

`define ADDR_W             16
`define CTRL_OFFSET        16'h8e00
`define PRIO_OFFSET        16'h8e04
`define SLOTCFG_OFFSET     16'h8e08
`define SLOTSTAT_OFFSET    16'h8e10
`define SCR_OFFSET         16'h8e18
`define XLATE_EN_OFFSET    16'h8e20
`define NODE_CTRL_BASE     16'h9000
`define NODE_CTRL_LAST     16'h93fc
`define NODE_STAT_BASE     16'h9400
`define NODE_STAT_LAST     16'h97fc

`define CTRL_RESET         32'h0000_0000
`define SCR_RESET          32'h0000_0000
`define XLATE_EN_RESET     2'h0

`define HASH_BIT           19
`define OFF_S1_BASE        8
`define OFF_S2_BASE        12
`define SCR_NS_ACCESS_BIT  0
`define XLATE_NS_BIT       0
`define XLATE_S_BIT        1

`define IN_ADDR_W          52
`define IN_ADDR_LSB        12
`define ID_W               16
`define IDX_W              8
`define ADDR_CHUNKS        5
`define ID_CHUNKS          2

`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// ### verilog/walk_cache_pkg.sv
// Types shared by the walk cache tuning register bank and its index calculator.
// Assumes walk_cache_defs.svh is on the include path.
`include "walk_cache_defs.svh"

package walk_cache_pkg;
	typedef enum logic {
		STAGE_ONE,
		STAGE_TWO
	} stage_t;

	typedef enum {
		WR_IDLE,
		WR_RESP
	} wr_state_t;

	typedef enum {
		RD_IDLE,
		RD_RESP
	} rd_state_t;

	typedef logic [`IDX_W-1:0] idx_t;
endpackage

// ### verilog/walk_cache_if.sv
// Carrier between the register bank and the walk cache index calculator.
// Assumes one clock; the calculator is purely combinational.
`timescale 1ns/1ns
`include "walk_cache_defs.svh"

interface walk_cache_if;
	logic [7:0]                 walkcache_off;
	logic                       hashed;
	logic [`IN_ADDR_W-1:0]      in_addr;
	logic [`ID_W-1:0]           asid;
	logic [`ID_W-1:0]           vmid;
	walk_cache_pkg::stage_t     stage;
	logic [1:0]                 level;
	logic                       inv_has_asid;
	walk_cache_pkg::idx_t       index;
	logic                       use_cache;
	logic                       scan_all;

	modport bank (
		output walkcache_off, hashed, in_addr, asid, vmid, stage, level, inv_has_asid,
		input  index, use_cache, scan_all
	);
	modport calc (
		input  walkcache_off, hashed, in_addr, asid, vmid, stage, level, inv_has_asid,
		output index, use_cache, scan_all
	);
endinterface

// ### verilog/walk_cache_index.sv
// Walk cache index, per-level enable and invalidation scope from the control bits.
// Assumes its request inputs are stable for the cycle in which they are used.
`timescale 1ns/1ns
`include "walk_cache_defs.svh"

module walk_cache_index (
	walk_cache_if.calc wc    // Control bits in, index results out
);
	logic [`IDX_W-1:0] addr_fold;
	logic [`IDX_W-1:0] id_fold;
	logic [2:0]        off_sel;

	genvar i;
	generate
		for (i = 0; i < `IDX_W; i++) begin : g_fold
			logic [`ADDR_CHUNKS-1:0] a_bits;
			logic [2*`ID_CHUNKS-1:0] id_bits;
			for (genvar c = 0; c < `ADDR_CHUNKS; c++) begin : g_a
				assign a_bits[c] = wc.in_addr[`IN_ADDR_LSB + c*`IDX_W + i];
			end
			for (genvar c = 0; c < `ID_CHUNKS; c++) begin : g_id
				assign id_bits[c]              = wc.asid[c*`IDX_W + i];
				assign id_bits[`ID_CHUNKS + c] = wc.vmid[c*`IDX_W + i];
			end
			assign addr_fold[i] = ^a_bits;
			assign id_fold[i]   = ^id_bits;
		end
	endgenerate

	always_comb begin
		off_sel = {wc.stage == walk_cache_pkg::STAGE_TWO, wc.level};
		wc.index = addr_fold;
		if (wc.hashed) begin
			wc.index = addr_fold ^ id_fold;
		end
		wc.use_cache = ~wc.walkcache_off[off_sel];
		wc.scan_all  = wc.hashed & ~wc.inv_has_asid;
	end
endmodule

// ### bench/walk_cache_tuning_regs_asserts.sv
// Concurrent checks on the walk cache tuning register bank top-level ports.
// Assumes the defs header on the include path and a single aclk domain.
`timescale 1ns/1ns
`include "walk_cache_defs.svh"

module walk_cache_tuning_regs_asserts (
	input wire logic                   aclk,            // Clock
	input wire logic                   aresetn,         // Reset, active low
	input wire logic                   s_axi_awvalid,   // Write address valid
	input wire logic                   s_axi_awready,   // Write address ready
	input wire logic                   s_axi_wvalid,    // Write data valid
	input wire logic                   s_axi_wready,    // Write data ready
	input wire logic [1:0]             s_axi_bresp,     // Write response
	input wire logic                   s_axi_bvalid,    // Write response valid
	input wire logic                   s_axi_bready,    // Write response ready
	input wire logic [`ADDR_W-1:0]     s_axi_araddr,    // Read address
	input wire logic                   s_axi_arvalid,   // Read address valid
	input wire logic                   s_axi_arready,   // Read address ready
	input wire logic [31:0]            s_axi_rdata,     // Read data
	input wire logic [1:0]             s_axi_rresp,     // Read response
	input wire logic                   s_axi_rvalid,    // Read data valid
	input wire logic                   s_axi_rready,    // Read data ready
	input wire logic                   lookup_valid,    // Lookup request
	input wire logic [`IN_ADDR_W-1:0]  lookup_addr,     // Input address
	input wire logic [`ID_W-1:0]       lookup_asid,     // Address space id
	input wire logic [`ID_W-1:0]       lookup_vmid,     // Machine id
	input wire logic                   lookup_stage2,   // Stage 2 walk
	input wire logic [1:0]             lookup_level,    // Walk level
	input wire logic                   lookup_inval,    // Invalidation
	input wire logic                   lookup_has_asid, // Invalidation has id
	input wire logic                   result_valid,    // Result valid
	input wire walk_cache_pkg::idx_t   result_index,    // Result index
	input wire logic                   result_use,      // Cache level in use
	input wire logic                   result_scan_all, // Scan whole cache
	input wire logic [7:0]             walkcache_off,   // Level disables
	input wire logic                   identifier_hashed_indexing // Hashed mode
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	function automatic logic [7:0] fold(input logic [`IN_ADDR_W-1:0] a,
		input logic [`ID_W-1:0] s, input logic [`ID_W-1:0] v, input logic h);
		logic [7:0] f;
		f = 8'h00;
		for (int c = 0; c < 5; c++) f ^= a[12+8*c +: 8];
		if (h) f ^= s[7:0] ^ s[15:8] ^ v[7:0] ^ v[15:8];
		return f;
	endfunction

	AST_RESET_QUIET: assert property (disable iff (1'b0) !aresetn |=> !s_axi_awready &&
		!s_axi_wready && !s_axi_arready && !s_axi_bvalid && !s_axi_rvalid && !result_valid)
		else $error("outputs active after reset");
	AST_AR_TO_R: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer not one cycle after address");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
		$stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read answer not held");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid &&
		$stable(s_axi_bresp)) else $error("write answer not held");
	AST_AW_TO_B: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer latency wrong");
	AST_UNMAPPED_RD: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[15:12] == 4'h0
		|=> s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read");
	AST_RESULT_VALID: assert property (lookup_valid |=> result_valid)
		else $error("lookup result missing");
	AST_LEVEL_USE: assert property (
		lookup_valid |=> result_use == !walkcache_off[{$past(lookup_stage2), $past(lookup_level)}])
		else $error("walk cache use does not follow its disable bit");
	AST_SCAN_ALL: assert property (lookup_valid |=> result_scan_all ==
		($past(lookup_inval) && identifier_hashed_indexing && !$past(lookup_has_asid)))
		else $error("scan all flag wrong");
	AST_INDEX: assert property (lookup_valid |=> result_index == fold($past(lookup_addr),
		$past(lookup_asid), $past(lookup_vmid), identifier_hashed_indexing))
		else $error("walk cache index wrong");
endmodule

bind walk_cache_tuning_regs walk_cache_tuning_regs_asserts chk (.*);

// ### bench/testbench.sv
// Self-checking bench for the walk cache tuning register bank.
// Assumes the defs header on the include path; bench is the only bus master.
`timescale 1ns/1ns
`include "walk_cache_defs.svh"

module testbench;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [`ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic lookup_valid = 0, lookup_stage2 = 0, lookup_inval = 0, lookup_has_asid = 0;
	logic [`IN_ADDR_W-1:0] lookup_addr = '0;
	logic [`ID_W-1:0] lookup_asid = '0, lookup_vmid = 16'h3c5a;
	logic [1:0] lookup_level = '0;
	logic result_valid, result_use, result_scan_all, identifier_hashed_indexing;
	walk_cache_pkg::idx_t result_index;
	logic [7:0] walkcache_off;
	int num_errors = 0, num_checks = 0, cycles = 0;
	localparam logic [51:0] addr_c = 52'hf_3a5c_1e7b_4d20;

	walk_cache_tuning_regs dut (.*);

	always #5 aclk = ~aclk;

	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			final_report();
		end
	end

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic axi_write(input logic [15:0] a, input logic [31:0] d, input logic ns);
		logic aw_ok, w_ok;
		aw_ok = 0;
		w_ok = 0;
		s_axi_awaddr <= a;
		s_axi_awprot <= {1'b0, ns, 1'b0};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_ok = 1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_ok = 1;
				s_axi_wvalid <= 1'b0;
			end
		end
		while (!s_axi_bvalid) @(posedge aclk);
		s_axi_bready <= 1'b1;
		do @(posedge aclk); while (!s_axi_bvalid);
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic axi_read(input logic [15:0] a, input logic ns);
		s_axi_araddr <= a;
		s_axi_arprot <= {1'b0, ns, 1'b0};
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		while (!s_axi_rvalid) @(posedge aclk);
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_rvalid);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask

	// Inval and has-asid travel in ih[1] and ih[0]
	task automatic lookup(input logic [2:0] sl, input logic [51:0] a, input logic [15:0] s,
		input logic [1:0] ih);
		lookup_stage2 <= sl[2];
		lookup_level <= sl[1:0];
		lookup_addr <= a;
		lookup_asid <= s;
		lookup_inval <= ih[1];
		lookup_has_asid <= ih[0];
		lookup_valid <= 1'b1;
		@(posedge aclk);
		lookup_valid <= 1'b0;
		@(posedge aclk);
		chk("result_valid", 32'h1, result_valid);
	endtask

	function automatic logic [7:0] exp_idx(input logic [51:0] a, input logic [15:0] s,
		input logic h);
		logic [7:0] f;
		f = 8'h00;
		for (int c = 0; c < 5; c++) f ^= a[12+8*c +: 8];
		if (h) f ^= s[7:0] ^ s[15:8] ^ lookup_vmid[7:0] ^ lookup_vmid[15:8];
		return f;
	endfunction

	task automatic t_reset();
		axi_read(`CTRL_OFFSET, 1'b0);
		chk("ctrl reset", `CTRL_RESET, rd);
		chk("walkcache_off reset", 32'h0, walkcache_off);
		axi_read(`PRIO_OFFSET, 1'b0);
		chk("prio read", 32'h0, rd);
		axi_read(16'h0ffc, 1'b0);
		chk("unmapped rresp", `RESP_SLVERR, rs);
		chk("unmapped rdata", 32'h0, rd);
		axi_write(16'h1000, 32'h1, 1'b0);
		chk("unmapped bresp", `RESP_SLVERR, rs);
		$display("test reset done");
	endtask

	task automatic t_levels();
		for (int i = 0; i < 8; i++) begin
			axi_write(`CTRL_OFFSET, 32'h1 << (8 + i), 1'b0);
			chk("ctrl bresp", `RESP_OKAY, rs);
			axi_read(`CTRL_OFFSET, 1'b0);
			chk("ctrl readback", 32'h1 << (8 + i), rd);
			chk("walkcache_off", 32'h1 << i, walkcache_off);
			for (int j = 0; j < 8; j++) begin
				lookup(3'(j), 52'h0, 16'h0, 2'b00);
				chk("result_use", 32'(i != j), result_use);
			end
		end
		$display("test levels done");
	endtask

	task automatic t_hash();
		for (int h = 0; h < 2; h++) begin
			axi_write(`CTRL_OFFSET, 32'(h) << `HASH_BIT, 1'b0);
			chk("hashed mode", 32'(h), identifier_hashed_indexing);
			lookup(3'd0, addr_c, 16'h0001, 2'b00);
			chk("index a", exp_idx(addr_c, 16'h0001, h[0]), result_index);
			lookup(3'd0, addr_c, 16'h0102, 2'b00);
			chk("index b", exp_idx(addr_c, 16'h0102, h[0]), result_index);
			lookup(3'd0, addr_c, 16'h0, 2'b10);
			chk("scan_all", 32'(h), result_scan_all);
			lookup(3'd0, addr_c, 16'h0, 2'b11);
			chk("scan_all with id", 32'h0, result_scan_all);
		end
		$display("test hash done");
	endtask

	task automatic t_nonsecure();
		axi_write(`CTRL_OFFSET, 32'h200, 1'b0);
		axi_read(`CTRL_OFFSET, 1'b1);
		chk("ns read hidden", 32'h0, rd);
		axi_write(`CTRL_OFFSET, 32'h400, 1'b1);
		chk("ns write bresp", `RESP_OKAY, rs);
		axi_read(`CTRL_OFFSET, 1'b0);
		chk("ns write dropped", 32'h200, rd);
		axi_write(`SCR_OFFSET, 32'h1, 1'b0);
		axi_read(`CTRL_OFFSET, 1'b1);
		chk("ns read open", 32'h200, rd);
		axi_write(`CTRL_OFFSET, 32'h400, 1'b1);
		axi_read(`CTRL_OFFSET, 1'b0);
		chk("ns write open", 32'h400, rd);
		axi_write(`SCR_OFFSET, 32'h0, 1'b0);
		$display("test nonsecure done");
	endtask

	task automatic t_enables();
		lookup(3'd0, 52'h0, 16'h0, 2'b10);
		for (int e = 1; e < 4; e++) begin
			axi_write(`XLATE_EN_OFFSET, 32'(e), 1'b0);
			axi_write(`CTRL_OFFSET, 32'h800, 1'b0);
			axi_read(`CTRL_OFFSET, 1'b0);
			chk("ctrl locked", 32'h400, rd);
		end
		axi_write(`XLATE_EN_OFFSET, 32'h0, 1'b0);
		axi_write(`CTRL_OFFSET, 32'h800, 1'b0);
		axi_read(`CTRL_OFFSET, 1'b0);
		chk("ctrl unlocked", 32'h800, rd);
		$display("test enables done");
	endtask

	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		t_reset();
		t_levels();
		t_hash();
		t_nonsecure();
		t_enables();
		final_report();
	end
endmodule
